// [gnd_relay_common.sv]
// Constants shared by the ground relay controller, and its failure timer leaf.
// Assumes one 125 MHz clock, synchronous active-high reset and a clock enable.

`timescale 1ns/100ps
`default_nettype none

package gnd_relay_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int NUM_PEERS = 8;
   localparam int SIZE_W    = 16;
   localparam int PRIO_W    = 8;
   localparam int RPM_W     = 12;
   localparam int TIME_W    = 9;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_FREQ_HZ  = 125_000_000;
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES  = (CLK_FREQ_HZ / 1000) * TICK_TIME_MS;
   localparam int TICK_CNT_W   = 24;

   // Failure timers count in tenths of a second
   localparam logic [TIME_W-1:0] FAIL_TIME_MIN     = 9'h00a;
   localparam logic [TIME_W-1:0] FAIL_TIME_MAX     = 9'h12c;
   localparam logic [TIME_W-1:0] FAIL_TIME_DEFAULT = 9'h00a;

   // ----------------------------------------------------------------------
   // Speed threshold
   // ----------------------------------------------------------------------
   localparam logic [RPM_W-1:0] CLOSE_RPM_MAX     = 12'hfa0;
   localparam logic [RPM_W-1:0] CLOSE_RPM_DEFAULT = 12'h3e8;

   // ----------------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      CLOSE_VOLT_FREQ,
      CLOSE_RPM_PICKUP,
      CLOSE_RPM_ECU,
      CLOSE_START_ACTIVE
   } close_cond_t;

   typedef enum logic {
      OPEN_AFTER_COOLDOWN,
      OPEN_AFTER_EXT_STOP
   } open_cond_t;

   typedef enum logic {
      RELAY_CONTINUOUS,
      RELAY_PULSE
   } relay_type_t;

   // Reset values of the relay state
   localparam logic RELAY_WANT_RESET = 1'b0;
   localparam logic OUTPUT_RESET     = 1'b0;

endpackage : gnd_relay_pkg

module gnd_fail_timer (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic              i_ce,
   input  wire logic              i_tick,
   input  wire logic              i_run,
   input  wire logic [8:0]        i_limit,
   output logic                   o_expired
);
   typedef struct packed {
      logic [8:0] count;
      logic       expired;
   } timer_state_t;

   timer_state_t state;
   timer_state_t next_state;

   // Counts tenths while running, holds expiry until the run condition drops
   always_comb begin
      next_state = state;
      if (!i_run) begin
         next_state = '0;
      end else if (i_tick && !state.expired) begin
         next_state.count = state.count + 9'h001;
         if (next_state.count >= i_limit) begin
            next_state.expired = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state <= '0;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   assign o_expired = state.expired;

endmodule : gnd_fail_timer

`default_nettype wire

// [gnd_relay_ctrl.sv]
// Ground relay controller of one genset: standalone close/open, busbar
// arbitration against peer controllers, continuous or pulse drive, and
// supervision of open and close failures, and of position failures in pulse type.
// Assumes peer data and plant status come from logic on the same clock;
// relay position feedbacks come from pins and are synchronised here.

`timescale 1ns/100ps
`default_nettype none

module gnd_relay_ctrl #(
   parameter int TICK_CYCLES = gnd_relay_pkg::TICK_CYCLES
) (
   input  wire logic                                             i_clk_sys,
   input  wire logic                                             i_rst,
   input  wire logic                                             i_ce,
   // Configuration
   input  wire logic                                             i_enable,
   input  wire logic                                             i_single_controller,
   input  wire gnd_relay_pkg::relay_type_t                       i_relay_type,
   input  wire gnd_relay_pkg::close_cond_t                       i_close_cond,
   input  wire gnd_relay_pkg::open_cond_t                        i_open_cond,
   input  wire logic [gnd_relay_pkg::RPM_W-1:0]                  i_close_rpm,
   input  wire logic [gnd_relay_pkg::TIME_W-1:0]                 i_close_alarm_time,
   input  wire logic [gnd_relay_pkg::TIME_W-1:0]                 i_open_fail_time,
   input  wire logic [gnd_relay_pkg::TIME_W-1:0]                 i_close_fail_time,
   input  wire logic [gnd_relay_pkg::TIME_W-1:0]                 i_pos_fail_time,
   // Genset status
   input  wire logic                                             i_volt_freq_within_range,
   input  wire logic [gnd_relay_pkg::RPM_W-1:0]                  i_speed_pickup_sensor_rpm,
   input  wire logic [gnd_relay_pkg::RPM_W-1:0]                  i_engine_control_unit_rpm,
   input  wire logic                                             i_start_active,
   input  wire logic                                             i_generator_breaker_closed,
   input  wire logic                                             i_cooldown_done,
   input  wire logic                                             i_extended_stop_done,
   input  wire logic                                             i_racked_out,
   input  wire logic [gnd_relay_pkg::SIZE_W-1:0]                 i_own_size,
   input  wire logic [gnd_relay_pkg::PRIO_W-1:0]                 i_own_priority,
   // Peer controllers
   input  wire logic [gnd_relay_pkg::NUM_PEERS-1:0]              i_peer_connected,
   input  wire logic [gnd_relay_pkg::NUM_PEERS-1:0]              i_peer_relay_closed,
   input  wire logic [gnd_relay_pkg::NUM_PEERS*gnd_relay_pkg::SIZE_W-1:0] i_peer_size,
   input  wire logic [gnd_relay_pkg::NUM_PEERS*gnd_relay_pkg::PRIO_W-1:0] i_peer_priority,
   // Relay position feedback pins
   input  wire logic                                             i_fb_on,
   input  wire logic                                             i_fb_off,
   // Relay drive
   output logic                                                  o_out_a,
   output logic                                                  o_out_b,
   output logic                                                  o_relay_closed,
   // Alarms
   output logic                                                  o_close_alarm,
   output logic                                                  o_open_fail,
   output logic                                                  o_close_fail,
   output logic                                                  o_pos_fail,
   output logic                                                  o_trip_generator_breaker_class,
   output logic                                                  o_block_genset
);
   import gnd_relay_pkg::*;

   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [TICK_CNT_W-1:0] tick_cnt;
      logic                  tick;
      logic [2:0]            on_sync;
      logic [2:0]            off_sync;
      logic                  fb_on;
      logic                  fb_off;
      logic                  want;
      logic                  pulse_open;
      logic                  pulse_close;
      logic                  out_a;
      logic                  out_b;
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;

   logic                 active;
   logic                 close_cond_met;
   logic                 open_cond_met;
   logic                 pos_closed;
   logic                 pos_open;
   logic                 pos_bad;
   logic [NUM_PEERS-1:0] peer_beats_me;
   logic                 better_grounded;
   logic                 is_best;
   logic                 close_alarm_exp;
   logic                 open_fail_exp;
   logic                 close_fail_exp;
   logic                 pos_fail_exp;

   // ----------------------------------------------------------------------
   // Peer arbitration
   // ----------------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NUM_PEERS; p++) begin : g_peer
         logic [SIZE_W-1:0] size;
         logic [PRIO_W-1:0] prio;
         assign size = i_peer_size[p*SIZE_W +: SIZE_W];
         assign prio = i_peer_priority[p*PRIO_W +: PRIO_W];
         assign peer_beats_me[p] = i_peer_connected[p] &&
                                   ((size > i_own_size) ||
                                    ((size == i_own_size) &&
                                     (prio > i_own_priority)));
      end
   endgenerate

   assign is_best         = ~|peer_beats_me;
   assign better_grounded = |(peer_beats_me & i_peer_relay_closed);

   // ----------------------------------------------------------------------
   // Conditions
   // ----------------------------------------------------------------------
   assign active = i_enable && !i_single_controller;

   always_comb begin
      unique case (i_close_cond)
         CLOSE_VOLT_FREQ:    close_cond_met = i_volt_freq_within_range;
         CLOSE_RPM_PICKUP:   close_cond_met = i_speed_pickup_sensor_rpm >= i_close_rpm;
         CLOSE_RPM_ECU:      close_cond_met = i_engine_control_unit_rpm >= i_close_rpm;
         CLOSE_START_ACTIVE: close_cond_met = i_start_active;
      endcase
   end

   assign open_cond_met = !i_generator_breaker_closed && i_cooldown_done &&
                          ((i_open_cond == OPEN_AFTER_COOLDOWN) ||
                           i_extended_stop_done);

   // Position as seen through the synchronised feedbacks
   always_comb begin
      if (i_relay_type == RELAY_PULSE) begin
         pos_closed = state.fb_on && !state.fb_off;
         pos_open   = state.fb_off && !state.fb_on;
         pos_bad    = state.fb_on == state.fb_off;
      end else begin
         pos_closed = state.fb_on;
         pos_open   = !state.fb_on;
         pos_bad    = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;

      // Tenth-second tick
      next_state.tick = 1'b0;
      if (state.tick_cnt == TICK_LAST) begin
         next_state.tick_cnt = '0;
         next_state.tick     = 1'b1;
      end else begin
         next_state.tick_cnt = state.tick_cnt + 24'h000001;
      end

      // Feedback synchronisers; a change counts once stages two and three agree
      next_state.on_sync  = {state.on_sync[1:0], i_fb_on};
      next_state.off_sync = {state.off_sync[1:0], i_fb_off};
      if (state.on_sync[1] == state.on_sync[2]) begin
         next_state.fb_on = state.on_sync[2];
      end
      if (state.off_sync[1] == state.off_sync[2]) begin
         next_state.fb_off = state.off_sync[2];
      end

      // Relay demand
      if (!active) begin
         next_state.want = 1'b0;
      end else if (!i_generator_breaker_closed) begin
         if (close_cond_met) begin
            next_state.want = 1'b1;
         end else if (open_cond_met) begin
            next_state.want = 1'b0;
         end
      end else if (is_best) begin
         next_state.want = 1'b1;
      end else if (better_grounded) begin
         // Old relay releases only once the better genset reports closed
         next_state.want = 1'b0;
      end
      if (i_racked_out && !state.want) begin
         next_state.want = 1'b0;
      end

      // Pulse drive
      if (!active || (i_relay_type != RELAY_PULSE)) begin
         next_state.pulse_open  = 1'b0;
         next_state.pulse_close = 1'b0;
      end else begin
         if (next_state.want && !state.want) begin
            next_state.pulse_close = 1'b1;
            next_state.pulse_open  = 1'b0;
         end else if (!next_state.want && state.want) begin
            next_state.pulse_open  = 1'b1;
            next_state.pulse_close = 1'b0;
         end else begin
            if (pos_closed || close_fail_exp) begin
               next_state.pulse_close = 1'b0;
            end
            if (pos_open || open_fail_exp) begin
               next_state.pulse_open = 1'b0;
            end
         end
      end

      // Output registers
      if (i_relay_type == RELAY_PULSE) begin
         next_state.out_a = next_state.pulse_open;
         next_state.out_b = next_state.pulse_close;
      end else begin
         next_state.out_a = next_state.want;
         next_state.out_b = OUTPUT_RESET;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state             <= '0;
         state.want        <= RELAY_WANT_RESET;
         state.out_a       <= OUTPUT_RESET;
         state.out_b       <= OUTPUT_RESET;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // Failure supervision
   // ----------------------------------------------------------------------
   gnd_fail_timer u_close_alarm (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_tick    (state.tick),
      .i_run     (active && state.want && !pos_closed),
      .i_limit   (i_close_alarm_time),
      .o_expired (close_alarm_exp)
   );

   gnd_fail_timer u_close_fail (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_tick    (state.tick),
      .i_run     (active && state.want && !pos_closed),
      .i_limit   (i_close_fail_time),
      .o_expired (close_fail_exp)
   );

   gnd_fail_timer u_open_fail (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_tick    (state.tick),
      .i_run     (active && !state.want && !pos_open),
      .i_limit   (i_open_fail_time),
      .o_expired (open_fail_exp)
   );

   gnd_fail_timer u_pos_fail (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_tick    (state.tick),
      .i_run     (active && pos_bad),
      .i_limit   (i_pos_fail_time),
      .o_expired (pos_fail_exp)
   );

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_out_a        = state.out_a;
   assign o_out_b        = state.out_b;
   assign o_relay_closed = pos_closed;
   assign o_close_alarm  = close_alarm_exp;
   assign o_open_fail    = open_fail_exp;
   assign o_close_fail   = close_fail_exp;
   assign o_pos_fail     = pos_fail_exp;

   // Default responses: open and position failures and the close alarm trip
   assign o_trip_generator_breaker_class = open_fail_exp || pos_fail_exp ||
                                           close_alarm_exp;
   assign o_block_genset = close_fail_exp;

endmodule : gnd_relay_ctrl

`default_nettype wire

// [gnd_relay_ctrl_properties.sv]
// Concurrent checks on the ports of the ground relay controller.
// Assumes it is bound to gnd_relay_ctrl with its ports joined by name.
`timescale 1ns/100ps
`default_nettype none
module gnd_relay_ctrl_properties (
   input wire logic                        i_clk_sys,
   input wire logic                        i_rst,
   input wire logic                        i_ce,
   input wire logic                        i_enable,
   input wire logic                        i_single_controller,
   input wire gnd_relay_pkg::relay_type_t  i_relay_type,
   input wire gnd_relay_pkg::close_cond_t  i_close_cond,
   input wire gnd_relay_pkg::open_cond_t   i_open_cond,
   input wire logic                        i_volt_freq_within_range,
   input wire logic                        i_generator_breaker_closed,
   input wire logic                        i_cooldown_done,
   input wire logic                        i_racked_out,
   input wire logic [7:0]                  i_peer_connected,
   input wire logic [7:0]                  i_peer_relay_closed,
   input wire logic                        o_out_a,
   input wire logic                        o_out_b,
   input wire logic                        o_relay_closed,
   input wire logic                        o_close_alarm,
   input wire logic                        o_open_fail,
   input wire logic                        o_close_fail,
   input wire logic                        o_pos_fail,
   input wire logic                        o_trip_generator_breaker_class,
   input wire logic                        o_block_genset
);
   import gnd_relay_pkg::*;
   logic cont;
   logic live;
   assign cont = (i_relay_type == RELAY_CONTINUOUS);
   assign live = i_ce && i_enable && !i_single_controller && cont;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ------------------------------------------
   // Demand and drive
   // ------------------------------------------
   disabled_low_a: assert property (cont && i_ce && (!i_enable || i_single_controller)
      |=> !o_out_a) else $error("relay driven while function disabled");
   alone_close_a: assert property (live && !i_generator_breaker_closed && !i_racked_out
      && i_close_cond == CLOSE_VOLT_FREQ && i_volt_freq_within_range |=> o_out_a)
      else $error("standalone close not taken");
   alone_open_a: assert property (live && !i_generator_breaker_closed
      && i_close_cond == CLOSE_VOLT_FREQ && !i_volt_freq_within_range
      && i_open_cond == OPEN_AFTER_COOLDOWN && i_cooldown_done |=> !o_out_a)
      else $error("standalone open not taken");
   racked_hold_a: assert property (live && i_racked_out && !o_out_a |=> !o_out_a)
      else $error("relay closed in racked out mode");
   transfer_overlap_a: assert property ($fell(o_out_a) && $past(live)
      && $past(i_generator_breaker_closed) |-> $past(|(i_peer_connected & i_peer_relay_closed)))
      else $error("own relay released before new ground closed");
   cont_no_b_a: assert property (cont && $past(cont) |-> !o_out_b)
      else $error("close pulse in continuous type");
   pulse_ends_a: assert property ($rose(o_out_b) |-> ##[1:80] !o_out_b)
      else $error("close pulse does not end");
   // ------------------------------------------
   // Supervision
   // ------------------------------------------
   close_alarm_cause_a: assert property ($rose(o_close_alarm) |-> !$past(o_relay_closed))
      else $error("close alarm with relay closed");
   open_fail_cause_a: assert property (cont && $past(cont) && $rose(o_open_fail)
      |-> !$past(o_out_a) && $past(o_relay_closed)) else $error("open fail without cause");
   fail_class_a: assert property (o_block_genset == o_close_fail
      && o_trip_generator_breaker_class == (o_open_fail || o_pos_fail || o_close_alarm))
      else $error("fail class routing wrong");
   pos_fail_pulse_a: assert property (o_pos_fail |-> $past(i_relay_type) == RELAY_PULSE)
      else $error("position fail outside pulse type");
endmodule : gnd_relay_ctrl_properties
`default_nettype wire

// [gnd_relay_ctrl_tb.sv]
// Self-checking bench of the ground relay controller and a relay model.
// Assumes the package, design, checker and relay model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module gnd_relay_ctrl_tb;
   import gnd_relay_pkg::*;
   localparam int TICK = 4;
   logic i_clk_sys, i_rst, i_ce, i_enable, i_single_controller, i_racked_out;
   relay_type_t i_relay_type;
   close_cond_t i_close_cond;
   open_cond_t  i_open_cond;
   logic [RPM_W-1:0] i_close_rpm, i_speed_pickup_sensor_rpm, i_engine_control_unit_rpm, lo;
   logic [TIME_W-1:0] i_close_alarm_time, i_open_fail_time, i_close_fail_time, i_pos_fail_time;
   logic i_volt_freq_within_range, i_start_active, i_generator_breaker_closed;
   logic i_cooldown_done, i_extended_stop_done, i_fb_on, i_fb_off, stuck, split;
   logic [SIZE_W-1:0] i_own_size;
   logic [PRIO_W-1:0] i_own_priority;
   logic [7:0] i_peer_connected, i_peer_relay_closed;
   logic [8*SIZE_W-1:0] i_peer_size;
   logic [8*PRIO_W-1:0] i_peer_priority;
   logic o_out_a, o_out_b, o_relay_closed, o_close_alarm, o_open_fail, o_close_fail;
   logic o_pos_fail, o_trip_generator_breaker_class, o_block_genset;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   gnd_relay_ctrl #(.TICK_CYCLES(TICK)) uut (.*);
   gnd_relay_hw_model relay (.i_clk_sys(i_clk_sys), .i_out_a(o_out_a), .i_out_b(o_out_b),
      .i_pulse(i_relay_type == RELAY_PULSE), .i_stuck(stuck), .i_split(split),
      .o_fb_on(i_fb_on), .o_fb_off(i_fb_off));
   task cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : cyc
   task chk(input logic [3:0] seen, input logic [3:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task note(input string s);
      $display("test done: %s", s);
   endtask : note
   task conclude;
      $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         conclude();
      end
   end
   // ------------------------------------------
   // Tests
   // ------------------------------------------
   initial begin
      {i_rst, i_ce, i_enable, i_single_controller, i_racked_out} = 5'h18;
      {i_volt_freq_within_range, i_start_active, i_generator_breaker_closed} = 3'h0;
      {i_cooldown_done, i_extended_stop_done, stuck, split} = 4'h0;
      i_relay_type = RELAY_CONTINUOUS;
      i_close_cond = CLOSE_VOLT_FREQ;
      i_open_cond = OPEN_AFTER_COOLDOWN;
      i_close_rpm = CLOSE_RPM_DEFAULT;
      {i_speed_pickup_sensor_rpm, i_engine_control_unit_rpm} = 24'h000000;
      {i_close_alarm_time, i_open_fail_time} = {2{FAIL_TIME_DEFAULT}};
      {i_close_fail_time, i_pos_fail_time} = {2{FAIL_TIME_DEFAULT}};
      {i_own_size, i_own_priority} = {16'h0100, 8'h05};
      {i_peer_connected, i_peer_relay_closed, i_peer_size, i_peer_priority} = '0;
      cyc(6);
      i_rst = 1'b0;
      i_volt_freq_within_range = 1'b1;
      cyc(5);
      chk(o_out_a, 1'b0);
      {i_enable, i_single_controller} = 2'b11;
      cyc(5);
      chk(o_out_a, 1'b0);
      {i_ce, i_single_controller} = 2'b00;
      cyc(3);
      chk(o_out_a, 1'b0);
      i_ce = 1'b1;
      cyc(2);
      chk(o_out_a, 1'b1);
      cyc(20);
      chk({o_relay_closed, o_close_alarm}, 2'b10);
      i_volt_freq_within_range = 1'b0;
      cyc(5);
      chk(o_out_a, 1'b1);
      i_cooldown_done = 1'b1;
      cyc(2);
      chk(o_out_a, 1'b0);
      cyc(20);
      chk(o_relay_closed, 1'b0);
      note("enable and standalone");
      i_close_cond = CLOSE_START_ACTIVE;
      i_open_cond = OPEN_AFTER_EXT_STOP;
      i_start_active = 1'b1;
      cyc(2);
      chk(o_out_a, 1'b1);
      i_start_active = 1'b0;
      cyc(5);
      chk(o_out_a, 1'b1);
      i_extended_stop_done = 1'b1;
      cyc(2);
      chk(o_out_a, 1'b0);
      for (int s = 0; s < 2; s++) begin
         i_close_rpm = s ? CLOSE_RPM_MAX : CLOSE_RPM_DEFAULT;
         i_close_cond = s ? CLOSE_RPM_ECU : CLOSE_RPM_PICKUP;
         lo = i_close_rpm - 12'h001;
         {i_speed_pickup_sensor_rpm, i_engine_control_unit_rpm} = s ? {i_close_rpm, lo} : {lo, i_close_rpm};
         cyc(3);
         chk(o_out_a, 1'b0);
         {i_speed_pickup_sensor_rpm, i_engine_control_unit_rpm} = s ? {lo, i_close_rpm} : {i_close_rpm, lo};
         cyc(2);
         chk(o_out_a, 1'b1);
         {i_speed_pickup_sensor_rpm, i_engine_control_unit_rpm} = 24'h000000;
         cyc(20);
      end
      i_close_cond = CLOSE_VOLT_FREQ;
      {i_racked_out, i_volt_freq_within_range} = 2'b11;
      cyc(5);
      chk(o_out_a, 1'b0);
      i_racked_out = 1'b0;
      cyc(20);
      chk(o_out_a, 1'b1);
      note("close and open conditions");
      {i_generator_breaker_closed, i_peer_connected} = {1'b1, 8'h03};
      {i_peer_size[31:0], i_peer_priority[15:0]} = {16'h0100, 16'h00ff, 8'h06, 8'h01};
      cyc(3);
      chk(o_out_a, 1'b1);
      i_peer_relay_closed = 8'h02;
      cyc(2);
      chk(o_out_a, 1'b0);
      i_peer_priority[15:8] = 8'h04;
      cyc(2);
      chk(o_out_a, 1'b1);
      {i_peer_connected, i_peer_relay_closed, i_peer_size[47:32]} = {8'h07, 8'h06, 16'h0200};
      cyc(2);
      chk(o_out_a, 1'b0);
      {i_generator_breaker_closed, i_peer_connected, i_volt_freq_within_range} = 10'h000;
      cyc(20);
      note("busbar arbitration");
      {stuck, i_volt_freq_within_range} = 2'b11;
      cyc(int'(FAIL_TIME_DEFAULT - 9'h002) * TICK);
      chk({o_close_alarm, o_close_fail}, 2'b00);
      cyc(4 * TICK);
      chk({o_close_alarm, o_close_fail, o_block_genset, o_trip_generator_breaker_class}, 4'hf);
      stuck = 1'b0;
      cyc(20);
      chk({o_relay_closed, o_close_fail}, 2'b10);
      {stuck, i_volt_freq_within_range} = 2'b10;
      cyc(14 * TICK);
      chk({o_open_fail, o_block_genset, o_trip_generator_breaker_class}, 3'b101);
      stuck = 1'b0;
      cyc(20);
      chk(o_open_fail, 1'b0);
      note("failure supervision");
      i_relay_type = RELAY_PULSE;
      i_volt_freq_within_range = 1'b1;
      cyc(2);
      chk({o_out_a, o_out_b}, 2'b01);
      cyc(20);
      chk({o_out_b, o_relay_closed}, 2'b01);
      i_volt_freq_within_range = 1'b0;
      cyc(2);
      chk({o_out_a, o_out_b}, 2'b10);
      cyc(20);
      chk({o_out_a, o_relay_closed}, 2'b00);
      split = 1'b1;
      cyc(14 * TICK);
      chk({o_pos_fail, o_trip_generator_breaker_class}, 2'b11);
      note("pulse drive");
      conclude();
   end
endmodule : gnd_relay_ctrl_tb
bind gnd_relay_ctrl gnd_relay_ctrl_properties chk_i (.*);
`default_nettype wire

// [gnd_relay_hw_model.sv]
// Behavioural ground relay with separate on and off position contacts.
// Assumes drive inputs change just after the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module gnd_relay_hw_model #(
   parameter int DELAY = 5
) (
   input  wire logic i_clk_sys,
   input  wire logic i_out_a,
   input  wire logic i_out_b,
   input  wire logic i_pulse,
   input  wire logic i_stuck,
   input  wire logic i_split,
   output logic      o_fb_on,
   output logic      o_fb_off
);
   logic pos = 1'b0;
   logic tgt = 1'b0;
   int   cnt = 0;
   always @(posedge i_clk_sys) begin
      if (!i_pulse)
         tgt <= i_out_a;
      else if (i_out_b)
         tgt <= 1'b1;
      else if (i_out_a)
         tgt <= 1'b0;
      if (tgt == pos || i_stuck)
         cnt <= 0;
      else if (cnt == DELAY) begin
         pos <= tgt;
         cnt <= 0;
      end else
         cnt <= cnt + 1;
   end
   // Split contacts show neither position, like a broken feedback wire
   assign o_fb_on  = pos && !i_split;
   assign o_fb_off = !pos && !i_split;
endmodule : gnd_relay_hw_model
`default_nettype wire
